// >>> design/hbw_map.svh
// Constants for the host byte write port and address latch.
// How it works
// RULE_01 - Host ties buffering, no-wait and width straps low for 8-bit zero wait.
// RULE_02 - Transfer strobe falls when ready, strobe high and protocol leaves RAM.
// RULE_03 - Host drives space select high for memory, low for registers.
// RULE_04 - Space, lane, direction follow inputs until strobe rise or second edge.
// RULE_05 - Address and data follow inputs until strobe rise or second edge.
// RULE_06 - Direction high means read, low write, independent of lane polarity.
// RULE_07 - RAM decodes bits 15..0 or 11..0; registers decode bits 4..0.
// RULE_08 - Select must be low by second edge after strobe falls, else blocked.
// RULE_09 - Data bus driven only while select low, strobe low, direction read.
// RULE_10 - Host settles direction before lowering select and strobe.
// RULE_11 - Host waits for ready high before a new strobe after a trigger.
// RULE_12 - Lane polarity strap zero: lane high is upper byte; one inverts.
// RULE_13 - Host settles byte lane before lowering select and strobe.
// RULE_14 - Trigger strap zero: lower first, upper triggers; one reverses.
// RULE_15 - Uncontended transfer strobe falls within 140 ns or 157 ns.
// RULE_16 - Contended transfer strobe falls within 6.0 us or 557 ns.
// RULE_17 - Transfer strobe low 200, 250, 333 or 400 ns by clock rate; the code holds it low 200, 248, 328 or 400 ns.
// RULE_18 - Hold latches act only in buffered mode; transparent passes through.
// RULE_19 - Hold control high follows inputs; low keeps values before its fall.
// RULE_20 - Buffered hold latches demultiplex a multiplexed host address bus.
// RULE_21 - Byte lane input is ignored in 16-bit operation.
// RULE_22 - Clock rate setting resets to 16 MHz; 10, 12, 16, 20 supported.
// RULE_23 - Ready goes low after a trigger byte, high after the word transfer.
`ifndef HBW_MAP_SVH
`define HBW_MAP_SVH
`define CLK_PERIOD_NS 8
`define XFER_LOW_20_NS 200
`define XFER_LOW_16_NS 250
`define XFER_LOW_12_NS 333
`define XFER_LOW_10_NS 400
`define XFER_LOW_20_CYC (`XFER_LOW_20_NS / `CLK_PERIOD_NS)
`define XFER_LOW_16_CYC (`XFER_LOW_16_NS / `CLK_PERIOD_NS)
`define XFER_LOW_12_CYC (`XFER_LOW_12_NS / `CLK_PERIOD_NS)
`define XFER_LOW_10_CYC (`XFER_LOW_10_NS / `CLK_PERIOD_NS)
`define FREQ_10 2'h0
`define FREQ_12 2'h1
`define FREQ_16 2'h2
`define FREQ_20 2'h3
`define FREQ_RESET `FREQ_16
`define LATCH_EDGES 2'h2
`define SMALL_RAM_MASK 16'h0fff
`define REG_MASK 16'h001f
`endif

// >>> design/hbw_pkg.sv
// Types shared by the host byte write port.
package hbw_pkg;
    typedef logic [1:0] freq_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACC = 2'b01,
        ST_PEND = 2'b11,
        ST_XFER = 2'b10
    } state_e;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic sel_n;
        logic strobe_n;
        logic rd;
        logic lane;
        logic mem;
    } host_s;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic mem;
    } xfer_s;
endpackage

// >>> design/host_byte_write_port_addr_latch.sv
// Host parallel write port with byte pairing and address hold latches.
`timescale 1ns/10ps
`include "hbw_map.svh"
module host_byte_write_port_addr_latch
    import hbw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host bus
    input wire host_s host_in,
    input wire logic [15:0] rd_word,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic handshake_ready_n,
    // Straps and controls
    input wire logic transparent_mode,
    input wire logic no_wait_mode_n,
    input wire logic width_mode_n,
    input wire logic lane_polarity_cfg,
    input wire logic trigger_byte_cfg,
    input wire logic addr_hold_ctl,
    input wire logic large_ram,
    input wire logic freq_load,
    input wire freq_t freq_sel,
    // Internal side
    input wire logic protocol_busy,
    output logic internal_xfer_strobe_n,
    output xfer_s xfer_out,
    output logic blocked,
    output freq_t freq_cfg
);

    // RULE_17 strobe width cycles
    function automatic logic [5:0] pulse_cycles(input freq_t f);
        logic [5:0] c;
        c = 6'(`XFER_LOW_16_CYC);
        unique case (f)
            `FREQ_10: c = 6'(`XFER_LOW_10_CYC);
            `FREQ_12: c = 6'(`XFER_LOW_12_CYC);
            `FREQ_16: c = 6'(`XFER_LOW_16_CYC);
            `FREQ_20: c = 6'(`XFER_LOW_20_CYC);
        endcase
        return c;
    endfunction

    // RULE_07 address decode width
    function automatic logic [15:0] decode_addr(input logic [15:0] a,
                                                input logic m,
                                                input logic big);
        logic [15:0] r;
        r = a & `REG_MASK;
        if (m) begin
            r = big ? a : (a & `SMALL_RAM_MASK);
        end
        return r;
    endfunction

    host_s front_q, front_d;
    host_s cap_q, cap_d;
    state_e st_q, st_d;
    logic [1:0] edge_q, edge_d;
    logic blk_q, blk_d;
    logic [7:0] hold_q, hold_d;
    logic [5:0] cnt_q, cnt_d;
    logic xstb_n_q, xstb_n_d;
    logic rdy_n_q, rdy_n_d;
    xfer_s xfer_q, xfer_d;
    logic [15:0] dout_q, dout_d;
    logic oe_q, oe_d;
    freq_t freq_q, freq_d;

    logic mode16;
    logic upper;
    logic trig;
    logic [7:0] wbyte;
    logic [15:0] word;

    // RULE_21 lane ignored when wide
    assign mode16 = width_mode_n;

    always_comb begin
        // Host pins pass one register stage so captures see settled levels.
        front_d = host_in;
        // RULE_18 RULE_19 RULE_20 address hold
        if (!transparent_mode && !addr_hold_ctl) begin
            front_d.addr = front_q.addr;
            front_d.sel_n = front_q.sel_n;
            front_d.lane = front_q.lane;
            front_d.mem = front_q.mem;
        end
        freq_d = freq_load ? freq_sel : freq_q;
        // RULE_09 data bus gating
        oe_d = !host_in.sel_n && !host_in.strobe_n && host_in.rd;
        // RULE_12 read byte lane
        dout_d = rd_word;
        if (!mode16) begin
            dout_d = {8'h00, (host_in.lane ^ lane_polarity_cfg) ?
                      rd_word[15:8] : rd_word[7:0]};
        end
    end

    always_comb begin
        st_d = st_q;
        cap_d = cap_q;
        edge_d = edge_q;
        blk_d = blk_q;
        hold_d = hold_q;
        cnt_d = cnt_q;
        xstb_n_d = xstb_n_q;
        rdy_n_d = rdy_n_q;
        xfer_d = xfer_q;
        // RULE_12 RULE_14 RULE_21 lane and trigger
        upper = cap_q.lane ^ lane_polarity_cfg;
        trig = mode16 || (upper ^ trigger_byte_cfg);
        wbyte = cap_q.data[7:0];
        word = upper ? {wbyte, hold_q} : {hold_q, wbyte};
        if (mode16) begin
            word = cap_q.data;
        end
        unique case (st_q)
            ST_IDLE: begin
                if (!front_q.strobe_n) begin
                    // RULE_04 RULE_05 first capture
                    cap_d = front_q;
                    edge_d = 2'h1;
                    blk_d = 1'b0;
                    st_d = ST_ACC;
                end
            end
            ST_ACC: begin
                if (!front_q.strobe_n) begin
                    // RULE_04 RULE_05 second edge capture
                    if (edge_q < `LATCH_EDGES) begin
                        cap_d = front_q;
                        edge_d = edge_q + 2'h1;
                        // RULE_08 late select blocks
                        if (edge_q + 2'h1 == `LATCH_EDGES &&
                            front_q.sel_n) begin
                            blk_d = 1'b1;
                        end
                    end
                end else if (blk_q || cap_q.sel_n || cap_q.rd) begin
                    // RULE_08 nothing moves
                    st_d = ST_IDLE;
                end else if (!trig) begin
                    // RULE_14 pairing hold latch
                    hold_d = wbyte;
                    st_d = ST_IDLE;
                end else begin
                    // RULE_23 ready low
                    rdy_n_d = 1'b0;
                    xfer_d.addr = decode_addr(cap_q.addr, cap_q.mem,
                                              large_ram);
                    xfer_d.data = word;
                    xfer_d.mem = cap_q.mem;
                    st_d = ST_PEND;
                end
            end
            ST_PEND: begin
                // RULE_02 RULE_15 RULE_16 start when free
                if (!protocol_busy) begin
                    xstb_n_d = 1'b0;
                    // A full count keeps the strobe low for all N cycles.
                    cnt_d = pulse_cycles(freq_q);
                    st_d = ST_XFER;
                end
            end
            ST_XFER: begin
                // RULE_17 timed low width
                if (cnt_q == 6'h01) begin
                    xstb_n_d = 1'b1;
                    // RULE_23 ready back high
                    rdy_n_d = 1'b1;
                    st_d = ST_IDLE;
                end
                cnt_d = cnt_q - 6'h1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            front_q <= '1;
            cap_q <= '1;
            st_q <= ST_IDLE;
            edge_q <= 2'h0;
            blk_q <= 1'b0;
            hold_q <= 8'h00;
            cnt_q <= 6'h00;
            xstb_n_q <= 1'b1;
            rdy_n_q <= 1'b1;
            xfer_q <= '0;
            dout_q <= 16'h0000;
            oe_q <= 1'b0;
            // RULE_22 clock rate default
            freq_q <= `FREQ_RESET;
        end else begin
            front_q <= front_d;
            cap_q <= cap_d;
            st_q <= st_d;
            edge_q <= edge_d;
            blk_q <= blk_d;
            hold_q <= hold_d;
            cnt_q <= cnt_d;
            xstb_n_q <= xstb_n_d;
            rdy_n_q <= rdy_n_d;
            xfer_q <= xfer_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            freq_q <= freq_d;
        end
    end

    assign data_out = dout_q;
    assign data_oe = oe_q;
    assign handshake_ready_n = rdy_n_q;
    assign internal_xfer_strobe_n = xstb_n_q;
    assign xfer_out = xfer_q;
    assign blocked = blk_q;
    assign freq_cfg = freq_q;

endmodule

// >>> tb/hbw_assertions.sv
// Checker for the host byte write port.
`timescale 1ns/10ps
`include "hbw_map.svh"
module hbw_checker
    import hbw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire host_s host_in,
    input wire logic data_oe,
    input wire logic handshake_ready_n,
    input wire logic freq_load,
    input wire freq_t freq_sel,
    input wire logic protocol_busy,
    input wire logic internal_xfer_strobe_n,
    input wire xfer_s xfer_out,
    input wire logic blocked,
    input wire freq_t freq_cfg
);
    wire xs = internal_xfer_strobe_n;
    wire rn = handshake_ready_n;
    logic [5:0] cnt_q, cnt_d, exp_w;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Counts the low cycles of the transfer strobe.
    always_comb begin
        cnt_d = xs ? 6'h0 : cnt_q + 6'h1;
        exp_w = freq_cfg == `FREQ_20 ? 6'(`XFER_LOW_20_CYC) :
            freq_cfg == `FREQ_16 ? 6'(`XFER_LOW_16_CYC) :
            freq_cfg == `FREQ_12 ? 6'(`XFER_LOW_12_CYC) : 6'(`XFER_LOW_10_CYC);
    end
    always_ff @(posedge clk or posedge rst)
        if (rst) cnt_q <= 6'h0; else cnt_q <= cnt_d;
    pulse_width_a: assert property (
        $rose(xs) && cnt_q != 6'h0 |-> cnt_q == exp_w) else $error("width");
    ready_lead_a: assert property (
        $fell(xs) |-> !rn) else $error("ready lead");
    ready_back_a: assert property (
        $rose(xs) |-> $rose(rn)) else $error("ready back");
    busy_wait_a: assert property (
        $fell(xs) |-> !$past(protocol_busy)) else $error("busy");
    prompt_start_a: assert property (
        $fell(rn) && !protocol_busy |-> ##[1:2] $fell(xs)) else $error("late");
    contend_bound_a: assert property (
        $fell(rn) |-> ##[1:750] !xs) else $error("contended late");
    drive_cond_a: assert property (
        data_oe |-> !$past(host_in.sel_n) && !$past(host_in.strobe_n) &&
        $past(host_in.rd)) else $error("drive");
    rate_load_a: assert property (
        freq_load |=> freq_cfg == $past(freq_sel)) else $error("rate");
    xfer_hold_a: assert property (
        !xs && !$fell(xs) |-> $stable(xfer_out)) else $error("hold");
    busy_c: cover property (protocol_busy && $fell(rn));
    block_c: cover property ($rose(blocked));
    drive_c: cover property ($rose(data_oe));
endmodule
bind host_byte_write_port_addr_latch hbw_checker chk_u (.clk, .rst,
    .host_in, .data_oe, .handshake_ready_n, .freq_load, .freq_sel,
    .protocol_busy, .internal_xfer_strobe_n, .xfer_out, .blocked, .freq_cfg);

// >>> tb/host_model.sv
// Host processor model making byte accesses.
`timescale 1ns/10ps
module host_model
    import hbw_pkg::*;
(
    // Clock and answer
    input wire logic clk,
    input wire logic ready_n,
    // Host bus
    output host_s host_o,
    output logic ale
);
    initial begin
        host_o = {32'h0, 5'h18};
        ale = 1'b1;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
        input logic ln, m, r, mux, bl, trg);
        @(posedge clk);
        host_o <= {a, 8'h0, d, 2'h3, r, ln, m};
        @(posedge clk);
        host_o.sel_n <= bl;
        host_o.strobe_n <= 1'b0;
        if (mux) begin
            @(posedge clk);
            ale <= 1'b0;
            host_o.addr <= ~a;
        end
        repeat (3) @(posedge clk);
        host_o.strobe_n <= 1'b1;
        host_o.sel_n <= 1'b1;
        @(posedge clk);
        host_o.data <= ~host_o.data;
        host_o.addr <= ~host_o.addr;
        ale <= 1'b1;
        for (int i = 0; i < 9 && trg && ready_n; i++) @(posedge clk);
        for (int i = 0; i < 900 && !ready_n; i++) @(posedge clk);
        @(posedge clk);
    endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the host byte write port.
`timescale 1ns/10ps
`include "hbw_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %0t %h %h", $time, g, e); end end
module tb_top
    import hbw_pkg::*;
;
    logic clk = 0, rst = 1, protocol_busy = 0, transparent_mode = 1;
    logic lane_polarity_cfg = 0, trigger_byte_cfg = 0, large_ram = 0;
    logic freq_load = 0, data_oe, handshake_ready_n, internal_xfer_strobe_n;
    logic addr_hold_ctl, blocked, saw_oe = 0, saw_blk = 0, width_mode_n = 0;
    logic [15:0] data_out;
    freq_t freq_sel = 2'h0, freq_cfg;
    host_s host_in;
    xfer_s xfer_out, ex;
    xfer_s q[$];
    int n_errors = 0, cmp_count = 0, cyc = 0, seed = 32'h5ced;
    initial forever #4 clk = ~clk;
    host_model host_u (.clk, .ready_n(handshake_ready_n), .host_o(host_in),
        .ale(addr_hold_ctl));
    host_byte_write_port_addr_latch dut_u (.clk, .rst, .host_in,
        .rd_word(16'h5a3c), .data_out, .data_oe, .handshake_ready_n,
        .transparent_mode, .no_wait_mode_n(1'b0), .width_mode_n,
        .lane_polarity_cfg, .trigger_byte_cfg, .addr_hold_ctl, .large_ram,
        .freq_load, .freq_sel, .protocol_busy, .internal_xfer_strobe_n,
        .xfer_out, .blocked, .freq_cfg);
    task automatic conclude();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // One word as two bytes, lane, trigger and buffering straps and rate code set from i, RAM size strap at random.
    task automatic word(input int i, input logic bz);
        logic [31:0] r;
        logic [15:0] d;
        xfer_s e;
        r = $random(seed);
        d = 16'($random(seed));
        @(posedge clk);
        {large_ram, lane_polarity_cfg, trigger_byte_cfg} <= {r[16], i[1:0]};
        {transparent_mode, freq_sel, freq_load} <= {i[2], i[1:0], 1'b1};
        protocol_busy <= bz;
        @(posedge clk);
        freq_load <= 1'b0;
        e.mem = r[17];
        e.data = d;
        e.addr = !r[17] ? r[15:0] & `REG_MASK :
            r[16] ? r[15:0] : r[15:0] & `SMALL_RAM_MASK;
        q.push_back(e);
        host_u.wr(r[15:0], i[0] ? d[15:8] : d[7:0], i[1] ^ i[0], r[17],
            1'b0, !i[2], 1'b0, 1'b0);
        host_u.wr(r[15:0], i[0] ? d[7:0] : d[15:8], !(i[1] ^ i[0]), r[17],
            1'b0, !i[2], 1'b0, 1'b1);
    endtask
    always @(posedge clk) begin
        cyc++;
        saw_oe <= saw_oe | (data_oe === 1'b1);
        saw_blk <= saw_blk | (blocked === 1'b1);
        if (data_oe === 1'b1) begin
            `CHK(data_out, {8'h00, (host_in.lane ^ lane_polarity_cfg) ?
                8'h5a : 8'h3c})
        end
        if (!rst && $fell(internal_xfer_strobe_n)) begin
            ex = q.size() > 0 ? q.pop_front() : 'x;
            `CHK(xfer_out, ex)
        end
        if (cyc > 30000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK({freq_cfg, handshake_ready_n, internal_xfer_strobe_n,
            data_oe}, 5'h16)
        for (int i = 0; i < 8; i++) word(i, 1'b0);
        fork
            word(5, 1'b1);
            begin repeat (40) @(posedge clk); protocol_busy <= 1'b0; end
        join
        `CHK({saw_blk, saw_oe}, 2'h0)
        host_u.wr(16'h3, 8'h5, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        `CHK(saw_blk, 1'b1)
        host_u.wr(16'h4, 8'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        host_u.wr(16'h4, 8'h0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        `CHK(saw_oe, 1'b1)
        // Wide mode joins no bytes, so a lone byte still triggers.
        width_mode_n <= 1'b1;
        q.push_back({16'h0012, 16'h00a7, 1'b0});
        host_u.wr(16'h12, 8'ha7, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        repeat (60) @(posedge clk);
        `CHK(q.size(), 0)
        conclude();
    end
endmodule
